// File: bench/scc_core_assertions.sv
// checker for the skip, call and clear-w core
// assumes it is bound onto scc_core
module scc_core_assertions (
  input wire logic CLK_I, // instruction clock
  input wire logic ARST_N_I, // async reset, low
  input wire logic [11:0] INSTR_I, // fetched word
  input wire logic [7:0] FREG_RDATA_I, // addressed file register
  input wire logic [4:0] FREG_ADDR_O, // file register address
  input wire logic [10:0] PC_O, // program counter
  input wire logic [7:0] W_O, // working register
  input wire logic [7:0] STATUS_O, // status register
  input wire scc_pkg::scc_push_t PUSH_O, // return stack push
  input wire logic FLUSH_O, // slot executed as nop
  input wire scc_pkg::scc_op_t OP_O // op executed last cycle
);
  import scc_pkg::*;

  // ==========================================
  // sequences
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence sk_s;
    !FLUSH_O && INSTR_I[11:8] == 4'h7;
  endsequence

  sequence sk_hit_s;
    sk_s ##0 FREG_RDATA_I[INSTR_I[7:5]];
  endsequence

  sequence sk_miss_s;
    sk_s ##0 !FREG_RDATA_I[INSTR_I[7:5]];
  endsequence

  sequence ca_s;
    !FLUSH_O && INSTR_I[11:8] == 4'h9;
  endsequence

  sequence ca_tail_s;
    FLUSH_O && $stable(STATUS_O) ##1 !FLUSH_O;
  endsequence

  sequence cw_s;
    !FLUSH_O && INSTR_I == 12'h040;
  endsequence

  // ==========================================
  // properties
  freg_addr_a: assert property (FREG_ADDR_O == INSTR_I[4:0])
    else $error("file register address does not follow the word");
  skip_set_a: assert property (sk_hit_s |=> FLUSH_O && OP_O == SCC_OP_SKIP && $stable(STATUS_O))
    else $error("taken skip did not flush the next slot");
  skip_clear_a: assert property (sk_miss_s |=> !FLUSH_O && OP_O == SCC_OP_SKIP && $stable(STATUS_O))
    else $error("untaken skip flushed or changed status");
  call_pc_a: assert property (ca_s |=> PC_O == {STATUS_O[6:5], 1'b0, $past(INSTR_I[7:0])})
    else $error("call target wrong");
  call_push_a: assert property (ca_s |=> PUSH_O.valid && PUSH_O.addr == $past(PC_O) + 11'h1)
    else $error("call push wrong");
  call_len_a: assert property (ca_s |=> ca_tail_s)
    else $error("call length or status wrong");
  flush_nop_a: assert property (FLUSH_O |=> !PUSH_O.valid && $stable(W_O) && OP_O == SCC_OP_NONE)
    else $error("flushed slot did not act as nop");
  clear_zero_a: assert property (cw_s |=> W_O == 8'h00 && STATUS_O == ($past(STATUS_O) | 8'h04))
    else $error("clear of working register wrong");
  pc_step_a: assert property (!(!FLUSH_O && INSTR_I[11:8] == 4'h9) |=> PC_O == $past(PC_O) + 11'h1)
    else $error("pc did not step by one");
endmodule

bind scc_core scc_core_assertions chk (
  .CLK_I(CLK_I),
  .ARST_N_I(ARST_N_I),
  .INSTR_I(INSTR_I),
  .FREG_RDATA_I(FREG_RDATA_I),
  .FREG_ADDR_O(FREG_ADDR_O),
  .PC_O(PC_O),
  .W_O(W_O),
  .STATUS_O(STATUS_O),
  .PUSH_O(PUSH_O),
  .FLUSH_O(FLUSH_O),
  .OP_O(OP_O)
);

// File: bench/scc_core_tb_top.sv
// self-checking bench for scc_core
// assumes scc_freg_model answers the file register reads
module scc_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import scc_pkg::*;
  logic CLK_I = 0, ARST_N_I = 0, FLUSH_O, e_fl = 0;
  logic [11:0] INSTR_I = '0, ins;
  logic [11:0] cw [6] = '{12'h7e0, 12'h9ff, 12'h9ab, 12'h040, 12'h040, 12'h700};
  logic [7:0] FREG_RDATA_I, W_O, STATUS_O, e_w = 8'h00, e_st = 8'h18;
  logic [4:0] FREG_ADDR_O;
  logic [10:0] PC_O, e_pc = 11'h7ff, np;
  scc_push_t PUSH_O, e_push = '0;
  scc_op_t OP_O, e_op = SCC_OP_NONE;
  int err_count = 0, compares = 0, cyc = 0, i;
  always #12.5 CLK_I = ~CLK_I;
  scc_core dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .INSTR_I(INSTR_I), .FREG_RDATA_I(FREG_RDATA_I),
    .FREG_ADDR_O(FREG_ADDR_O), .PC_O(PC_O), .W_O(W_O), .STATUS_O(STATUS_O), .PUSH_O(PUSH_O),
    .FLUSH_O(FLUSH_O), .OP_O(OP_O));
  scc_freg_model fm (.addr_i(FREG_ADDR_O), .rdata_o(FREG_RDATA_I));
  function logic [10:0] call_pc(logic [7:0] st, logic [7:0] k);
    return {st[6:5], 1'b0, k};
  endfunction
  task results;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // a hang is cut after 1000 cycles, well past the 408 the run needs
  always @(posedge CLK_I) if (++cyc == 1000) begin
    err_count++;
    results;
  end
  // ====
  // main sequence
  initial begin
    void'($urandom(32'h5d5604c5));
    for (i = 0; i < 32; i++) fm.mem[i] = 8'($urandom);
    fm.mem[0] = 8'h80;
    repeat (8) @(negedge CLK_I);
    ARST_N_I = 1;
    for (i = 0; i < 400; i++) begin
      compares++;
      if ({PC_O, W_O, STATUS_O, FLUSH_O, PUSH_O, OP_O} !== {e_pc, e_w, e_st, e_fl, e_push, e_op}) begin
        err_count++;
        $display("[FAIL] %0t state mismatch, pc %h", $time, PC_O);
      end
      case ($urandom % 4)
        0: ins = {4'h7, 8'($urandom)};
        1: ins = {4'h9, 8'($urandom)};
        2: ins = 12'h040;
        default: ins = 12'($urandom);
      endcase
      if (i < 6) ins = cw[i];
      INSTR_I = ins;
      np = e_pc + 11'h1;
      e_push = '0;
      e_op = SCC_OP_NONE;
      if (!e_fl && ins[11:8] == 4'h7) e_op = SCC_OP_SKIP;
      if (!e_fl && ins[11:8] == 4'h9) begin
        e_op = SCC_OP_CALL;
        e_push = {1'b1, np};
        np = call_pc(e_st, ins[7:0]);
      end
      if (!e_fl && ins == 12'h040) e_st[2] = 1'b1;
      e_fl = e_op == SCC_OP_CALL || (e_op == SCC_OP_SKIP && fm.mem[ins[4:0]][ins[7:5]]);
      e_pc = np;
      @(negedge CLK_I);
    end
    results;
  end
endmodule

// File: bench/scc_freg_model.sv
// file register model on the core's data side
// assumes the bench loads mem before the first fetch
module scc_freg_model (
  input wire logic [4:0] addr_i, // read address
  output logic [7:0] rdata_o // addressed contents
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [32];
  assign rdata_o = mem[addr_i];
endmodule

// File: rtl/scc_core.sv
// execution of the skip-if-set, call and clear-w instructions
// assumes the environment feeds one fetched word per instruction cycle and
// returns the addressed file register contents combinationally
//
// Notes on behaviour
// RQ1: 0111 bbbf ffff decodes as bit test skip
// RQ2: set bit flushes next fetch, two cycles
// RQ3: 1001 kkkk kkkk loads immediate into pc low
// RQ4: call pushes pc plus one onto stack
// RQ5: call takes pc 10:9 from status, clears 8
// RQ6: call lasts two cycles, flags unchanged
// RQ7: 0000 0100 0000 clears working register
// RQ8: clear-w sets zero flag only
// RQ9: bit zero is lsb; test is read-only
`include "scc_regs.svh"
module scc_core (
  input wire logic CLK_I, // instruction clock
  input wire logic ARST_N_I, // async reset, low
  input wire logic [11:0] INSTR_I, // fetched instruction word
  input wire logic [7:0] FREG_RDATA_I, // contents of addressed file register
  output logic [4:0] FREG_ADDR_O, // file register read address
  output logic [10:0] PC_O, // program counter
  output logic [7:0] W_O, // working register
  output logic [7:0] STATUS_O, // status register
  output scc_pkg::scc_push_t PUSH_O, // return stack push, top_of_stack entry
  output logic FLUSH_O, // current fetch is executed as nop
  output scc_pkg::scc_op_t OP_O // op executed last cycle, one-hot
);
  import scc_pkg::*;

  // ==========================================
  // signals

  // decoded fields of the fetched word
  logic is_skip;
  logic is_call;
  logic is_clear_w;
  logic [2:0] bit_idx;
  logic [7:0] imm;

  // bit test and class of the word in execute
  logic [7:0] bit_sel;
  logic bit_hit;
  scc_op_t cls;
  logic clear_live;

  // program counter group
  logic [10:0] pc_q;
  logic [10:0] pc_d;

  // working and status register group
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic [7:0] status_q;
  logic [7:0] status_d;

  // pipeline control group
  logic flush_q;
  logic flush_d;
  scc_push_t push_q;
  scc_push_t push_d;
  scc_op_t op_q;
  scc_op_t op_d;

  // ==========================================
  // helpers

  // address of the next word; the pc group and the push share this sum
  function automatic logic [10:0] seq_next(input logic [10:0] pc);
    seq_next = pc + 11'h001;
  endfunction

  // call target: page bits from status, bit 8 forced low, immediate below
  function automatic logic [10:0] call_target(input logic [7:0] status, input logic [7:0] k);
    call_target = {status[`SCC_STATUS_PAGE_HI:`SCC_STATUS_PAGE_LO], 1'b0, k}; // RQ5
  endfunction

  // a flushed slot is a nop whatever its bits say, so it is tested first
  function automatic scc_op_t classify(input logic flushed, input logic skip, input logic call);
    if (flushed) begin
      classify = SCC_OP_NONE;
    end else if (skip) begin
      classify = SCC_OP_SKIP;
    end else if (call) begin
      classify = SCC_OP_CALL;
    end else begin
      classify = SCC_OP_NONE;
    end
  endfunction

  // ==========================================
  // decode

  scc_decode u_dec (
    .instr_i(INSTR_I),
    .is_skip_o(is_skip),
    .is_call_o(is_call),
    .is_clear_working_reg_o(is_clear_w),
    .bit_idx_o(bit_idx),
    .faddr_o(FREG_ADDR_O),
    .imm_o(imm)
  );

  always_comb begin
    cls = classify(flush_q, is_skip, is_call);
    // the clear word shares no opcode bits with skip or call, so only
    // a pending flush can cancel it
    clear_live = !flush_q && is_clear_w; // RQ7
  end

  // ==========================================
  // bit test

  // one gate per bit, or-ed together, instead of a variable index;
  // the register contents are only looked at, never written back
  for (genvar b = 0; b < 8; b++) begin : g_bit
    assign bit_sel[b] = FREG_RDATA_I[b] && (bit_idx == 3'(b)); // RQ9
  end

  assign bit_hit = |bit_sel;

  // ==========================================
  // program counter

  always_comb begin
    pc_d = seq_next(pc_q);
    case (cls)
      SCC_OP_CALL: begin
        pc_d = call_target(status_q, imm); // RQ3 RQ5
      end
      SCC_OP_SKIP: begin
        // a taken skip still steps by one; the following slot is flushed
        pc_d = seq_next(pc_q); // RQ2
      end
      SCC_OP_NONE: begin
        pc_d = seq_next(pc_q);
      end
      default: begin
        pc_d = seq_next(pc_q);
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pc_q <= `SCC_PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ==========================================
  // working and status registers

  always_comb begin
    w_d = w_q;
    status_d = status_q;
    case (cls)
      SCC_OP_SKIP: begin
        // the bit test moves no flag, taken or not
        status_d = status_q; // RQ1
      end
      SCC_OP_CALL: begin
        status_d = status_q; // RQ6
      end
      SCC_OP_NONE: begin
        if (clear_live) begin
          w_d = 8'h00; // RQ7
          // only the zero flag moves; page and other bits are held
          status_d[`SCC_STATUS_Z] = 1'b1; // RQ8
        end
      end
      default: begin
        w_d = w_q;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      w_q <= `SCC_W_RST;
      status_q <= `SCC_STATUS_RST;
    end else begin
      w_q <= w_d;
      status_q <= status_d;
    end
  end

  // ==========================================
  // pipeline control

  always_comb begin
    flush_d = 1'b0;
    push_d = '{valid: 1'b0, addr: 11'h000};
    op_d = cls;
    case (cls)
      SCC_OP_SKIP: begin
        flush_d = bit_hit; // RQ2
      end
      SCC_OP_CALL: begin
        // the return address is the word after the call; the stack is outside
        push_d = '{valid: 1'b1, addr: seq_next(pc_q)}; // RQ4
        // the word prefetched behind the call is wrong-path, so drop it
        flush_d = 1'b1; // RQ6
      end
      SCC_OP_NONE: begin
        flush_d = 1'b0;
      end
      default: begin
        op_d = SCC_OP_NONE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      flush_q <= 1'b0;
      push_q <= '{valid: 1'b0, addr: 11'h000};
      op_q <= SCC_OP_NONE;
    end else begin
      flush_q <= flush_d;
      push_q <= push_d;
      op_q <= op_d;
    end
  end

  // ==========================================
  // outputs

  always_comb begin
    PC_O = pc_q;
    W_O = w_q;
    STATUS_O = status_q;
    PUSH_O = push_q;
    FLUSH_O = flush_q;
    OP_O = op_q;
  end
endmodule

// File: rtl/scc_decode.sv
// pure instruction field decoder
// assumes a 12-bit instruction word from program memory
`include "scc_regs.svh"
module scc_decode (
  input wire logic [11:0] instr_i, // fetched word
  output logic is_skip_o, // bit test skip if set
  output logic is_call_o, // subroutine call
  output logic is_clear_working_reg_o, // clear working register
  output logic [2:0] bit_idx_o, // tested bit index
  output logic [4:0] faddr_o, // file register address
  output logic [7:0] imm_o // call immediate
);
  // ==========================================
  // field decode
  always_comb begin
    is_skip_o = (instr_i[11:8] == `SCC_OP_SKIP_SET); // RQ1
    is_call_o = (instr_i[11:8] == `SCC_OP_CALL); // RQ3
    is_clear_working_reg_o = (instr_i == `SCC_OP_CLEAR_WORKING_REG); // RQ7
    bit_idx_o = instr_i[7:5];
    faddr_o = instr_i[4:0];
    imm_o = instr_i[7:0];
  end
endmodule

// File: rtl/scc_pkg.sv
// types for the skip/call/clear instruction subset
// assumes scc_regs.svh supplies the numeric constants
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_OP_NONE = 3'b001,
    SCC_OP_SKIP = 3'b010,
    SCC_OP_CALL = 3'b100
  } scc_op_t;

  typedef struct packed {
    logic valid;
    logic [10:0] addr;
  } scc_push_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } scc_wwrite_t;
endpackage

// File: rtl/scc_regs.svh
// constants for the skip/call/clear instruction subset
// assumes a 12-bit instruction word and an 11-bit program counter
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
// ==========================================
// opcode patterns
`define SCC_OP_SKIP_SET 4'h7
`define SCC_OP_CALL 4'h9
`define SCC_OP_CLEAR_WORKING_REG 12'h040
// ==========================================
// status bit positions
`define SCC_STATUS_Z 2
`define SCC_STATUS_PAGE_LO 5
`define SCC_STATUS_PAGE_HI 6
// ==========================================
// reset values
`define SCC_PC_RST 11'h7ff
`define SCC_W_RST 8'h00
`define SCC_STATUS_RST 8'h18
`endif
